/* File: logic/usc_defines.vh */
// register offsets, field positions and encodings of the serial core
`ifndef USC_DEFINES_VH
`define USC_DEFINES_VH

`define USC_ADDR_W        3
`define USC_REG_DATA      3'h0
`define USC_REG_CSA       3'h1
`define USC_REG_CSB       3'h2
`define USC_REG_CSC       3'h3
`define USC_REG_BAUD_LO   3'h4
`define USC_REG_BAUD_HI   3'h5

// control_status_a
`define USC_A_RXC         7
`define USC_A_TXC         6
`define USC_A_DRE         5
`define USC_A_FE          4
`define USC_A_DOR         3
`define USC_A_PE          2
`define USC_A_U2X         1
// control_status_b
`define USC_B_RXEN        4
`define USC_B_TXEN        3
`define USC_B_CS2         2
`define USC_B_RXB8        1
`define USC_B_TXB8        0
// control_status_c
`define USC_C_DIR         7
`define USC_C_SYNC        6
`define USC_C_PM1         5
`define USC_C_PM0         4
`define USC_C_SBS         3
`define USC_C_CS1         2
`define USC_C_CS0         1
`define USC_C_POL         0

`define USC_CSC_RESET     8'h06
`define USC_CS_NINE       3'h7
`define USC_BITS_FIVE     4'h5
`define USC_BITS_EIGHT    4'h8
`define USC_BITS_NINE     4'h9
`define USC_OVS_NORMAL    4'hf
`define USC_OVS_DOUBLE    4'h7
`define USC_MID_NORMAL    4'h7
`define USC_MID_DOUBLE    4'h3
`define USC_BAUD_W        12

`endif

/* File: logic/usc_core.v */
// serial transceiver core: baud generator, clocking, framing, parity, errors
`include "usc_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module usc_core #(
  parameter BAUD_W = `USC_BAUD_W
) (
  // clock and reset
  input  wire       clock,
  input  wire       nrst,
  // register port
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // serial lines
  input  wire       serial_in_pin,
  output reg        serial_out_pin,
  // synchronous clock pin
  input  wire       sync_clock_pin_in,
  output reg        sync_clock_pin_out,
  output wire       sync_clock_pin_oe,
  // event outputs
  output wire       irq_rx_complete,
  output wire       irq_tx_complete,
  output wire       irq_data_empty
);

  function [3:0] data_bits;
    input [2:0] cs;
    begin
      if (cs == `USC_CS_NINE) begin
        data_bits = `USC_BITS_NINE;
      end else if (cs[2]) begin
        data_bits = `USC_BITS_EIGHT;
      end else begin
        data_bits = `USC_BITS_FIVE + {2'h0, cs[1:0]};
      end
    end
  endfunction

  // control registers
  reg  [BAUD_W-1:0] baud_divisor_q;
  reg  [7:0]        csc_q;
  reg               rx_en_q;
  reg               tx_en_q;
  reg               cs2_q;
  reg               txb8_q;
  reg               u2x_q;
  reg               txc_q;
  reg               dor_q;

  wire       sync_select  = csc_q[`USC_C_SYNC];
  wire       sync_master  = sync_select & csc_q[`USC_C_DIR];
  wire       double_speed = u2x_q & ~sync_select;
  wire       pol          = csc_q[`USC_C_POL];
  wire       par_en       = csc_q[`USC_C_PM1];
  wire       par_odd      = csc_q[`USC_C_PM0];
  wire       two_stops    = csc_q[`USC_C_SBS];
  // one format shared by both directions; a change mid-frame corrupts both
  wire [2:0] char_size    = {cs2_q, csc_q[`USC_C_CS1], csc_q[`USC_C_CS0]};
  wire [3:0] nbits        = data_bits(char_size);
  wire [3:0] ovs_last     = double_speed ? `USC_OVS_DOUBLE : `USC_OVS_NORMAL;
  wire [3:0] ovs_mid      = double_speed ? `USC_MID_DOUBLE : `USC_MID_NORMAL;

  wire wr_data = wr & (addr == `USC_REG_DATA);
  wire rd_data = rd & (addr == `USC_REG_DATA);
  wire wr_csa  = wr & (addr == `USC_REG_CSA);
  wire wr_lo   = wr & (addr == `USC_REG_BAUD_LO);

  // baud generator
  reg  [BAUD_W-1:0] baud_cnt_q;
  wire baud_tick = (baud_cnt_q == {BAUD_W{1'b0}});

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      baud_cnt_q <= {BAUD_W{1'b0}};
    end else if (baud_tick || wr_lo) begin
      // the low-byte write restarts the period with the new divisor
      baud_cnt_q <= wr_lo ? {baud_divisor_q[BAUD_W-1:8], wdata}
                          : baud_divisor_q;
    end else begin
      baud_cnt_q <= baud_cnt_q - {{(BAUD_W-1){1'b0}}, 1'b1};
    end
  end

  // external clock: two synchroniser stages, then an edge detector
  reg xck_s1_q;
  reg xck_s2_q;
  reg xck_s3_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      xck_s1_q <= 1'b0;
      xck_s2_q <= 1'b0;
      xck_s3_q <= 1'b0;
    end else begin
      xck_s1_q <= sync_clock_pin_in;
      xck_s2_q <= xck_s1_q;
      xck_s3_q <= xck_s2_q;
    end
  end

  // master clock toggles on every tick, so one bit takes two ticks
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_clock_pin_out <= 1'b0;
    end else if (!sync_master) begin
      sync_clock_pin_out <= pol;
    end else if (baud_tick) begin
      sync_clock_pin_out <= ~sync_clock_pin_out;
    end
  end
  assign sync_clock_pin_oe = sync_master;

  // slave edges ignore the baud counter entirely
  wire rise = sync_master ? (baud_tick & ~sync_clock_pin_out)
                          : (xck_s2_q & ~xck_s3_q);
  wire fall = sync_master ? (baud_tick & sync_clock_pin_out)
                          : (~xck_s2_q & xck_s3_q);
  wire change_edge = sync_select & (pol ? fall : rise);
  wire sample_edge = sync_select & (pol ? rise : fall);

  // serial data input synchroniser
  reg rxd_s1_q;
  reg rxd_q;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxd_s1_q <= 1'b1;
      rxd_q    <= 1'b1;
    end else begin
      rxd_s1_q <= serial_in_pin;
      rxd_q    <= rxd_s1_q;
    end
  end

  // transmitter prescaler for asynchronous modes
  reg  [3:0] tx_pre_q;
  wire       tx_step = sync_select ? change_edge
                     : (baud_tick & (tx_pre_q == ovs_last));
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_pre_q <= 4'h0;
    end else if (sync_select) begin
      tx_pre_q <= 4'h0;
    end else if (baud_tick) begin
      tx_pre_q <= (tx_pre_q == ovs_last) ? 4'h0 : tx_pre_q + 4'h1;
    end
  end

  // transmit buffer and shifter
  reg        txb_full_q;
  reg  [8:0] txb_q;
  reg        tx_busy_q;
  reg  [3:0] tx_idx_q;
  reg  [8:0] tx_sh_q;
  reg        tx_par_q;
  reg        tx_busy_d;
  reg  [3:0] tx_idx_d;
  reg  [8:0] tx_sh_d;
  reg        tx_par_d;
  reg        tx_load;
  reg        tx_done;
  reg        tx_out_d;
  wire [3:0] tx_last = nbits + {3'h0, par_en} + {3'h0, two_stops} + 4'h1;
  // upper bits beyond the character size are dropped when written
  wire [8:0] tx_mask = ~(9'h1ff << nbits);

  always @* begin
    tx_busy_d = tx_busy_q;
    tx_idx_d  = tx_idx_q;
    tx_sh_d   = tx_sh_q;
    tx_par_d  = tx_par_q;
    tx_load   = 1'b0;
    tx_done   = 1'b0;
    if (tx_step && tx_en_q) begin
      if (tx_busy_q && tx_idx_q != tx_last) begin
        tx_idx_d = tx_idx_q + 4'h1;
      end else begin
        if (tx_busy_q) begin
          tx_done = ~txb_full_q;
        end
        tx_busy_d = txb_full_q;
        tx_load   = txb_full_q;
        tx_idx_d  = 4'h0;
        if (txb_full_q) begin
          tx_sh_d  = txb_q;
          tx_par_d = (^txb_q) ^ par_odd;
        end
      end
    end
    if (!tx_busy_d) begin
      tx_out_d = 1'b1;
    end else if (tx_idx_d == 4'h0) begin
      tx_out_d = 1'b0;
    end else if (tx_idx_d <= nbits) begin
      tx_out_d = tx_sh_d[tx_idx_d - 4'h1];
    end else if (par_en && tx_idx_d == nbits + 4'h1) begin
      tx_out_d = tx_par_d;
    end else begin
      tx_out_d = 1'b1;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_busy_q      <= 1'b0;
      tx_idx_q       <= 4'h0;
      tx_sh_q        <= 9'h000;
      tx_par_q       <= 1'b0;
      serial_out_pin <= 1'b1;
      txb_full_q     <= 1'b0;
      txb_q          <= 9'h000;
    end else begin
      tx_busy_q      <= tx_busy_d;
      tx_idx_q       <= tx_idx_d;
      tx_sh_q        <= tx_sh_d;
      tx_par_q       <= tx_par_d;
      serial_out_pin <= tx_en_q ? tx_out_d : 1'b1;
      if (wr_data) begin
        txb_full_q <= 1'b1;
        txb_q      <= {txb8_q, wdata} & tx_mask;
      end else if (tx_load) begin
        txb_full_q <= 1'b0;
      end
    end
  end

  // receiver
  reg        rx_busy_q;
  reg  [3:0] rx_ph_q;
  reg  [3:0] rx_idx_q;
  reg  [8:0] rx_sh_q;
  reg        rx_pbit_q;
  wire       rx_start_async = ~sync_select & baud_tick & ~rx_busy_q & ~rxd_q;
  wire       rx_start_sync  = sample_edge & ~rx_busy_q & ~rxd_q;
  wire       rx_samp = rx_busy_q & (sync_select ? sample_edge
                     : (baud_tick & (rx_ph_q == ovs_mid)));
  wire [3:0] rx_stop_idx = nbits + {3'h0, par_en} + 4'h1;
  wire [8:0] rx_data = rx_sh_q >> (`USC_BITS_NINE - nbits);
  wire       rx_end  = rx_en_q & rx_samp & (rx_idx_q == rx_stop_idx);
  wire       rx_perr = par_en & ((^rx_data) ^ par_odd ^ rx_pbit_q);

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_busy_q <= 1'b0;
      rx_ph_q   <= 4'h0;
      rx_idx_q  <= 4'h0;
      rx_sh_q   <= 9'h000;
      rx_pbit_q <= 1'b0;
    end else if (!rx_en_q) begin
      rx_busy_q <= 1'b0;
    end else if (rx_start_async) begin
      rx_busy_q <= 1'b1;
      rx_ph_q   <= 4'h0;
      rx_idx_q  <= 4'h0;
    end else if (rx_start_sync) begin
      rx_busy_q <= 1'b1;
      rx_idx_q  <= 4'h1;
    end else if (rx_busy_q) begin
      if (baud_tick) begin
        rx_ph_q <= (rx_ph_q == ovs_last) ? 4'h0 : rx_ph_q + 4'h1;
      end
      if (rx_samp) begin
        rx_idx_q <= rx_idx_q + 4'h1;
        if (rx_idx_q == 4'h0 && rxd_q) begin
          // a start bit gone high by mid-bit was noise
          rx_busy_q <= 1'b0;
        end else if (rx_idx_q == rx_stop_idx) begin
          // second stop bit is never looked at
          rx_busy_q <= 1'b0;
        end else if (rx_idx_q != 4'h0 && rx_idx_q <= nbits) begin
          rx_sh_q <= {rxd_q, rx_sh_q[8:1]};
        end else begin
          rx_pbit_q <= rxd_q;
        end
      end
    end
  end

  // two-entry receive buffer: {frame error, parity error, data}
  reg  [10:0] rxf_q [0:1];
  reg  [1:0]  rxf_cnt_q;
  wire        rx_pop  = rd_data & (rxf_cnt_q != 2'h0);
  wire        rx_full = (rxf_cnt_q == 2'h2) & ~rx_pop;
  wire        rx_push = rx_end & ~rx_full;
  wire [1:0]  rx_wpos = rxf_cnt_q - {1'b0, rx_pop};
  wire [10:0] rx_head = rxf_q[0];

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rxf_q[0]  <= 11'h000;
      rxf_q[1]  <= 11'h000;
      rxf_cnt_q <= 2'h0;
    end else begin
      if (rx_pop) begin
        rxf_q[0] <= rxf_q[1];
      end
      if (rx_push) begin
        rxf_q[rx_wpos[0]] <= {~rxd_q, rx_perr, rx_data};
      end
      rxf_cnt_q <= rx_wpos + {1'b0, rx_push};
    end
  end

  // register writes; hardware set beats a software clear
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      baud_divisor_q <= {BAUD_W{1'b0}};
      csc_q          <= `USC_CSC_RESET;
      rx_en_q        <= 1'b0;
      tx_en_q        <= 1'b0;
      cs2_q          <= 1'b0;
      txb8_q         <= 1'b0;
      u2x_q          <= 1'b0;
      txc_q          <= 1'b0;
      dor_q          <= 1'b0;
    end else begin
      if (wr_lo) begin
        baud_divisor_q[7:0] <= wdata;
      end
      if (wr && addr == `USC_REG_BAUD_HI) begin
        baud_divisor_q[BAUD_W-1:8] <= wdata[BAUD_W-9:0];
      end
      if (wr && addr == `USC_REG_CSC) begin
        csc_q <= wdata;
      end
      if (wr && addr == `USC_REG_CSB) begin
        rx_en_q <= wdata[`USC_B_RXEN];
        tx_en_q <= wdata[`USC_B_TXEN];
        cs2_q   <= wdata[`USC_B_CS2];
        txb8_q  <= wdata[`USC_B_TXB8];
      end
      if (wr_csa) begin
        u2x_q <= wdata[`USC_A_U2X];
      end
      if (tx_done) begin
        txc_q <= 1'b1;
      end else if (wr_csa && wdata[`USC_A_TXC]) begin
        txc_q <= 1'b0;
      end
      if (rx_end && rx_full) begin
        dor_q <= 1'b1;
      end else if (rx_pop) begin
        dor_q <= 1'b0;
      end
    end
  end

  // read data, one cycle after the strobe
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    case (addr)
      `USC_REG_DATA: begin
        rd_mux = rx_head[7:0];
      end
      `USC_REG_CSA: begin
        rd_mux[`USC_A_RXC] = irq_rx_complete;
        rd_mux[`USC_A_TXC] = txc_q;
        rd_mux[`USC_A_DRE] = irq_data_empty;
        rd_mux[`USC_A_FE]  = rx_head[10];
        rd_mux[`USC_A_DOR] = dor_q;
        rd_mux[`USC_A_PE]  = rx_head[9];
        rd_mux[`USC_A_U2X] = u2x_q;
      end
      `USC_REG_CSB: begin
        rd_mux[`USC_B_RXEN] = rx_en_q;
        rd_mux[`USC_B_TXEN] = tx_en_q;
        rd_mux[`USC_B_CS2]  = cs2_q;
        rd_mux[`USC_B_RXB8] = rx_head[8];
        rd_mux[`USC_B_TXB8] = txb8_q;
      end
      `USC_REG_CSC: begin
        rd_mux = csc_q;
      end
      `USC_REG_BAUD_LO: begin
        rd_mux = baud_divisor_q[7:0];
      end
      `USC_REG_BAUD_HI: begin
        rd_mux[BAUD_W-9:0] = baud_divisor_q[BAUD_W-1:8];
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

  assign irq_rx_complete = (rxf_cnt_q != 2'h0);
  assign irq_tx_complete = txc_q;
  assign irq_data_empty  = ~txb_full_q;

endmodule

`default_nettype wire

/* File: bench/usc_core_asserts.sv */
// bound checker watching the serial core ports
`include "usc_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module usc_asserts (
  // clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // pins and events
  input wire logic       serial_out_pin,
  input wire logic       sync_clock_pin_out,
  input wire logic       sync_clock_pin_oe,
  input wire logic       irq_rx_complete,
  input wire logic       irq_tx_complete,
  input wire logic       irq_data_empty
);
  logic [7:0] csc_q;
  logic [7:0] csb_q;
  logic [7:0] lo_q;
  logic [3:0] hi_q;
  logic       dbl_q;
  logic       last_q;
  logic [9:0] run_q;
  wire        master = csc_q[`USC_C_SYNC] & csc_q[`USC_C_DIR];
  wire        div1 = lo_q == 8'h01 && hi_q == 4'h0;
  wire        async1 = !csc_q[`USC_C_SYNC] && div1 && csb_q[`USC_B_TXEN];
  // shadow of the configuration, so timing checks know the mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      csc_q <= `USC_CSC_RESET;
      csb_q <= 8'h00;
      lo_q <= 8'h00;
      hi_q <= 4'h0;
      dbl_q <= 1'b0;
      last_q <= 1'b1;
      run_q <= 10'h3ff;
    end else begin
      if (wr && addr == `USC_REG_CSC) csc_q <= wdata;
      if (wr && addr == `USC_REG_CSB) csb_q <= wdata;
      if (wr && addr == `USC_REG_BAUD_LO) lo_q <= wdata;
      if (wr && addr == `USC_REG_BAUD_HI) hi_q <= wdata[3:0];
      if (wr && addr == `USC_REG_CSA) dbl_q <= wdata[`USC_A_U2X];
      last_q <= serial_out_pin;
      // saturating run length of the transmit line since its last change
      run_q <= (serial_out_pin != last_q) ? 10'h000 : run_q + {9'h0, run_q != 10'h3ff};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_oe_mode: assert property (sync_clock_pin_oe == master)
    else $error("clock pin enable does not follow master mode");
  a_pin_unused: assert property (!master && !$past(master) && $stable(csc_q)
    |-> sync_clock_pin_out == csc_q[`USC_C_POL])
    else $error("clock pin moves outside master mode");
  a_master_step: assert property (master && $past(master) && div1
    && $changed(sync_clock_pin_out)
    |=> $stable(sync_clock_pin_out) ##1 ($changed(sync_clock_pin_out) || !master))
    else $error("master clock not toggling every second cycle");
  a_idle_high: assert property (!csb_q[`USC_B_TXEN] && !$past(csb_q[`USC_B_TXEN])
    |-> serial_out_pin)
    else $error("transmit line low while transmitter off");
  a_buf_fill: assert property (wr && addr == `USC_REG_DATA |=> !irq_data_empty)
    else $error("buffer still empty after data write");
  a_buf_drain: assert property ($fell(irq_data_empty) && csb_q[`USC_B_TXEN] && div1
    |-> ##[1:1000] irq_data_empty)
    else $error("transmit buffer never moved to shifter");
  a_bit_normal: assert property (serial_out_pin != last_q && async1 && !dbl_q
    |-> run_q >= 10'd31)
    else $error("normal speed bit shorter than 32 cycles");
  a_bit_double: assert property (serial_out_pin != last_q && async1 && dbl_q
    |-> run_q >= 10'd15)
    else $error("double speed bit shorter than 16 cycles");
  a_status_flags: assert property (rd && addr == `USC_REG_CSA
    |=> rdata[7:5] == {$past(irq_rx_complete), $past(irq_tx_complete), $past(irq_data_empty)})
    else $error("status read disagrees with event outputs");
endmodule
bind usc_core usc_asserts i_chk (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .serial_out_pin(serial_out_pin),
  .sync_clock_pin_out(sync_clock_pin_out), .sync_clock_pin_oe(sync_clock_pin_oe),
  .irq_rx_complete(irq_rx_complete), .irq_tx_complete(irq_tx_complete),
  .irq_data_empty(irq_data_empty));
`default_nettype wire

/* File: bench/usc_remote.sv */
// far-side serial transceiver model
`timescale 1ns/1ns
`default_nettype none
module usc_remote (
  // clock
  input wire logic clock,
  // serial lines seen from the far side
  input wire logic rx_line,
  output var logic tx_line
);
  initial tx_line = 1'b1;
  task automatic bit_out(input logic v, input int cyc);
    tx_line <= v;
    repeat (cyc) @(posedge clock);
  endtask
  // bad_stop holds the stop low only past mid-bit; the false start that follows is rejected as noise
  task automatic send(input logic [8:0] d, input int n, input logic [1:0] pm, input int stops,
                      input int bclk, input logic bad_par, input logic bad_stop);
    logic p;
    p = ^(d & ((9'h001 << n) - 9'h001)) ^ pm[0] ^ bad_par;
    @(posedge clock);
    bit_out(1'b0, bclk);
    for (int i = 0; i < n; i++) bit_out(d[i], bclk);
    if (pm[1]) bit_out(p, bclk);
    if (bad_stop) bit_out(1'b0, bclk / 2 + 4);
    bit_out(1'b1, bclk * stops);
  endtask
  task automatic recv(input int n, input logic par, input int bclk,
                      output logic [8:0] d, output logic p, output logic s);
    int t;
    d = 9'h000;
    t = 0;
    while (rx_line !== 1'b0 && t < 4000) begin
      @(posedge clock);
      t++;
    end
    repeat (bclk / 2) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      repeat (bclk) @(posedge clock);
      d[i] = rx_line;
    end
    if (par) repeat (bclk) @(posedge clock);
    p = rx_line;
    repeat (bclk) @(posedge clock);
    s = (t < 4000) ? rx_line : 1'bx;
  endtask
endmodule
`default_nettype wire

/* File: bench/usc_core_bench.sv */
// testbench: registers, frame formats, errors, buffering and clock modes
`include "usc_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module usc_core_bench;
  localparam logic [2:0] r_dat = `USC_REG_DATA;
  localparam logic [2:0] r_csa = `USC_REG_CSA;
  localparam logic [2:0] r_csb = `USC_REG_CSB;
  localparam logic [2:0] r_csc = `USC_REG_CSC;
  logic       clock;
  logic       nrst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic       ext_ck;
  logic [1:0] ext_div;
  wire  [7:0] rdata;
  wire        to_dut, from_dut, ck_out, ck_oe, irq_rx, irq_tx, irq_empty;
  int         fail_count;
  int         total_checks;
  // csc values: 5 odd 2 stops, 6 even, 7 none 2 stops, 8 odd, 9 even 2 stops, 8 double
  logic [7:0] f_csc [6] = '{8'h38, 8'h22, 8'h0c, 8'h36, 8'h2e, 8'h06};
  logic [8:0] f_val [6] = '{9'h1f3, 9'h0ca, 9'h155, 9'h0a6, 9'h1b4, 9'h05c};
  int         f_bits [6] = '{5, 6, 7, 8, 9, 8};
  // the core does not drive the clock pin in async mode, so it shows the moving ext_ck
  wire        ck_pin = ck_oe ? ck_out : ext_ck;
  usc_core i_dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_in_pin(to_dut), .serial_out_pin(from_dut),
    .sync_clock_pin_in(ck_pin), .sync_clock_pin_out(ck_out), .sync_clock_pin_oe(ck_oe),
    .irq_rx_complete(irq_rx), .irq_tx_complete(irq_tx), .irq_data_empty(irq_empty));
  usc_remote p (.clock(clock), .rx_line(from_dut), .tx_line(to_dut));
  initial clock = 1'b0;
  always #25 clock = ~clock;
  // slave clock at an eighth of the system clock, well inside the quarter limit
  always @(posedge clock) begin
    ext_div <= ext_div + 2'h1;
    if (ext_div == 2'h3) ext_ck <= ~ext_ck;
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check({1'b0, rdata & m}, {1'b0, e});
  endtask
  task automatic wait_empty;
    int t;
    t = 0;
    @(posedge clock);
    while (irq_empty !== 1'b1 && t < 2000) begin
      @(posedge clock);
      t++;
    end
    check({8'h0, irq_empty}, 9'h001);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    finish_test;
  end
  initial begin
    logic [8:0] d, m, sv, got;
    logic       gp, gs, v;
    int         n, bclk;
    {nrst, wr, rd, addr, wdata, ext_ck, ext_div} = '0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    rd_chk(r_csa, 8'hff, 8'h20);
    rd_chk(r_csb, 8'hff, 8'h00);
    rd_chk(r_csc, 8'hff, `USC_CSC_RESET);
    rd_chk(3'h6, 8'hff, 8'h00);
    check({8'h0, from_dut}, 9'h001);
    wr_reg(`USC_REG_BAUD_HI, 8'h00);
    wr_reg(`USC_REG_BAUD_LO, 8'h01);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      n = f_bits[i];
      m = (9'h001 << n) - 9'h001;
      bclk = (i == 5) ? 16 : 32;
      d = f_val[i];
      sv = ~d & m;
      wr_reg(r_csa, (i == 5) ? 8'h02 : 8'h00);
      wr_reg(r_csc, f_csc[i]);
      wr_reg(r_csb, {3'h0, 2'h3, n == 9, 1'b0, d[8]});
      fork
        begin
          wr_reg(r_dat, d[7:0]);
          p.recv(n, f_csc[i][5], bclk, got, gp, gs);
        end
        p.send(sv, n, f_csc[i][5:4], f_csc[i][3] + 1, bclk, 1'b0, 1'b0);
      join
      repeat (64) @(posedge clock);
      check(got, d & m);
      if (f_csc[i][5]) check({8'h0, gp}, {8'h0, ^(d & m) ^ f_csc[i][4]});
      check({8'h0, gs}, 9'h001);
      rd_chk(r_csa, 8'h9c, 8'h80);
      // the ninth bit belongs to the head entry, so read it before the pop
      if (n == 9) rd_chk(r_csb, 8'h02, {6'h0, sv[8], 1'b0});
      rd_chk(r_dat, 8'hff, sv[7:0]);
    end
    $display("test formats done");
    wr_reg(r_csa, 8'h00);
    wr_reg(r_csc, 8'h26);
    for (int k = 0; k < 2; k++) begin
      p.send(9'h03c, 8, 2'h2, 1, 32, k == 0, k == 1);
      rd_chk(r_csa, 8'h1c, (k == 0) ? 8'h04 : 8'h10);
      rd_chk(r_dat, 8'hff, 8'h3c);
    end
    $display("test errors done");
    wr_reg(r_csc, 8'h06);
    for (int k = 1; k < 4; k++) p.send(9'h011 * k, 8, 2'h0, 1, 32, 1'b0, 1'b0);
    rd_chk(r_csa, 8'h88, 8'h88);
    rd_chk(r_dat, 8'hff, 8'h11);
    rd_chk(r_dat, 8'hff, 8'h22);
    rd_chk(r_csa, 8'h80, 8'h00);
    $display("test overrun done");
    wr_reg(r_csa, 8'h40);
    rd_chk(r_csa, 8'h42, 8'h00);
    fork
      begin
        wr_reg(r_dat, 8'h5a);
        wait_empty;
        wr_reg(r_dat, 8'hc3);
      end
      begin
        p.recv(8, 1'b0, 32, got, gp, gs);
        check(got, 9'h05a);
        p.recv(8, 1'b0, 32, got, gp, gs);
        check(got, 9'h0c3);
      end
    join
    repeat (64) @(posedge clock);
    rd_chk(r_csa, 8'h60, 8'h60);
    wr_reg(r_csa, 8'h40);
    rd_chk(r_csa, 8'h40, 8'h00);
    $display("test back to back done");
    wr_reg(r_csc, 8'h46);
    fork
      wr_reg(r_dat, 8'h96);
      p.recv(8, 1'b0, 8, got, gp, gs);
    join
    check(got, 9'h096);
    check({8'h0, gs}, 9'h001);
    check({8'h0, ck_oe}, 9'h000);
    $display("test slave clock done");
    wr_reg(r_csb, 8'h00);
    wr_reg(r_csc, 8'hc0);
    repeat (8) @(posedge clock);
    #1;
    v = ck_out;
    check({8'h0, ck_oe}, 9'h001);
    repeat (2) @(posedge clock);
    #1;
    check({8'h0, ck_out}, {8'h0, ~v});
    wr_reg(r_csc, 8'h06);
    repeat (3) @(posedge clock);
    #1;
    check({7'h0, ck_oe, ck_out}, 9'h000);
    $display("test clock modes done");
    finish_test;
  end
endmodule
`default_nettype wire
